// [common/trf_pkg.sv]
`default_nettype none
package trf_pkg;
	// measured reading: signed, 1/16 degree steps
	localparam int RAW_W = 16;
	localparam int FRAC_W = 4;
	localparam int RES_W = 12;
	localparam int BYTE_W = 8;
	localparam int CFG_RANGE_BIT = 2;
	localparam logic [7:0] STD_MAX_CODE = 8'h7f;
	localparam logic [7:0] STD_MIN_CODE = 8'h00;
	localparam logic [7:0] EXT_OFFSET = 8'h40;
	localparam logic [7:0] EXT_MAX_CODE = 8'hff;
	localparam logic [3:0] LOW_PAD = 4'h0;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	typedef struct packed {
		logic [7:0] whole;
		logic [7:0] frac;
	} trf_result_type;

	typedef struct packed {
		logic remote;
		logic signed [RAW_W-1:0] reading;
	} trf_sample_type;
endpackage
`default_nettype wire

// [rtl/trf_code_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module trf_code_calc
	import trf_pkg::*;
(
	// reading in, range select
	input wire logic signed [RAW_W-1:0] reading,
	input wire logic wide,
	// formatted two-byte code
	output trf_result_type code
);
	logic signed [RAW_W-1:0] whole_deg;
	logic signed [RAW_W-1:0] shifted;

	// arithmetic shift floors toward minus infinity, so fraction stays positive
	always_comb begin
		whole_deg = reading >>> FRAC_W;
		shifted = wide ? (whole_deg + RAW_W'(signed'({8'h00, EXT_OFFSET}))) : whole_deg;
		code.frac = {reading[FRAC_W-1:0], LOW_PAD};
		if (shifted < 0) begin
			code.whole = STD_MIN_CODE;
			code.frac = '0;
		end else if (!wide && shifted > RAW_W'(STD_MAX_CODE)) begin
			code.whole = STD_MAX_CODE;
			code.frac = '0;
		end else if (wide && shifted > RAW_W'(EXT_MAX_CODE)) begin
			code.whole = EXT_MAX_CODE;
			code.frac = '0;
		end else begin
			code.whole = shifted[BYTE_W-1:0];
		end
	end
endmodule
`default_nettype wire

// [rtl/trf_formatter.sv]
`timescale 1ns/1ps
`default_nettype none
module trf_formatter
	import trf_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// configuration
	input wire logic [7:0] config_reg,
	// conversion engine
	input wire logic conv_start,
	input wire logic sample_valid,
	input wire trf_sample_type sample,
	// result storage
	output trf_result_type local_result,
	output trf_result_type remote_result,
	output logic result_wr,
	output logic wide_active
);
	trf_result_type code;
	logic wide_q;
	trf_result_type local_q, remote_q;
	logic wr_q;

	trf_code_calc trf_code_calc_inst (
		.reading(sample.reading),
		.wide(wide_q),
		.code(code)
	);

	// range latched at conversion start so stored data never mixes formats
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wide_q <= 1'b0;
		end else if (conv_start) begin
			wide_q <= config_reg[CFG_RANGE_BIT];
		end
	end

	// result store per channel
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			local_q <= RESULT_RST;
			remote_q <= RESULT_RST;
			wr_q <= 1'b0;
		end else begin
			wr_q <= sample_valid;
			if (sample_valid && sample.remote) begin
				remote_q <= code;
			end
			if (sample_valid && !sample.remote) begin
				local_q <= code;
			end
		end
	end

	assign local_result = local_q;
	assign remote_result = remote_q;
	assign result_wr = wr_q;
	assign wide_active = wide_q;

	// range only moves on a conversion start
	chk_range_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		!$past(conv_start) |-> wide_q == $past(wide_q))
		else $error("range changed outside conversion start");

	// conversion start takes the configuration bit
	chk_range_take: assert property (@(posedge core_clk) disable iff (!nrst)
		conv_start
		|=> wide_q == $past(config_reg[CFG_RANGE_BIT]))
		else $error("range bit not taken at conversion start");

	// low nibble of the fraction byte never carries data
	chk_low_pad: assert property (@(posedge core_clk) disable iff (!nrst)
		local_q.frac[3:0] == 4'h0 && remote_q.frac[3:0] == 4'h0)
		else $error("low byte padding not zero");

	// standard range ceiling, local channel
	chk_std_max: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && !wide_q |=> local_q.whole <= STD_MAX_CODE)
		else $error("standard code above 127");

	// standard range ceiling, remote channel
	chk_std_max_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && !wide_q
		|=> remote_q.whole <= STD_MAX_CODE)
		else $error("remote standard code above 127");

	// saturation drops the fraction too, so the code reads exactly 127
	chk_std_sat_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && !wide_q && sample.reading > 16'sd2047
		|=> local_q == {STD_MAX_CODE, 8'h00})
		else $error("local standard saturation wrong");

	// same saturation on the remote channel
	chk_std_sat_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && !wide_q && sample.reading > 16'sd2047
		|=> remote_q == {STD_MAX_CODE, 8'h00})
		else $error("remote standard saturation wrong");

	// below zero reads as zero in the standard range
	chk_std_neg: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && !wide_q && sample.reading < 0
		|=> local_q.whole == 8'h00)
		else $error("negative not zero");

	// remote negative clears the whole result, fraction included
	chk_std_neg_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && !wide_q && sample.reading < 0
		|=> remote_q == 16'h0000)
		else $error("remote negative not zero");

	// in-range standard code is the plain whole degree
	chk_std_code_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && !wide_q && sample.reading >= 0
		&& sample.reading <= 16'sd2047
		|=> local_q.whole == $past(sample.reading[11:4]))
		else $error("local standard code wrong");

	// same on the remote channel
	chk_std_code_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && !wide_q && sample.reading >= 0
		&& sample.reading <= 16'sd2047
		|=> remote_q.whole == $past(sample.reading[11:4]))
		else $error("remote standard code wrong");

	// zero degrees lands on the offset itself
	chk_ext_zero: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && wide_q && sample.reading[15:4] == 12'h000
		|=> remote_q.whole == EXT_OFFSET)
		else $error("extended offset wrong");

	// zero degrees on the local channel
	chk_ext_zero_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && wide_q && sample.reading[15:4] == 12'h000
		|=> local_q.whole == EXT_OFFSET)
		else $error("local extended offset wrong");

	// 8-bit sum wraps on purpose: minus 64 maps to zero, 191 to all ones
	chk_ext_code_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && wide_q && sample.reading >= -16'sd1024
		&& sample.reading <= 16'sd3071
		|=> local_q.whole == $past(sample.reading[11:4]) + EXT_OFFSET)
		else $error("local extended code wrong");

	// same on the remote channel
	chk_ext_code_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && wide_q && sample.reading >= -16'sd1024
		&& sample.reading <= 16'sd3071
		|=> remote_q.whole == $past(sample.reading[11:4]) + EXT_OFFSET)
		else $error("remote extended code wrong");

	// below minus 64 clears the remote result
	chk_ext_low: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && wide_q && sample.reading < -16'sd1024
		|=> remote_q == 16'h0000)
		else $error("extended low clamp wrong");

	// below minus 64 clears the local result
	chk_ext_low_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && wide_q && sample.reading < -16'sd1024
		|=> local_q == 16'h0000)
		else $error("local extended low clamp wrong");

	// above 191 saturates remote to all ones
	chk_ext_high: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && wide_q && sample.reading > 16'sd3071
		|=> remote_q.whole == 8'hff)
		else $error("extended high clamp wrong");

	// above 191 saturates local, fraction dropped
	chk_ext_high_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && wide_q && sample.reading > 16'sd3071
		|=> local_q == {EXT_MAX_CODE, 8'h00})
		else $error("local extended high clamp wrong");

	// standard fraction kept on the local channel
	chk_frac_keep: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && !wide_q && sample.reading >= 0
		&& sample.reading < 16'sd2048
		|=> local_q.frac[7:4] == $past(sample.reading[3:0]))
		else $error("fraction lost");

	// standard fraction kept on the remote channel
	chk_frac_rem: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && !wide_q && sample.reading >= 0
		&& sample.reading < 16'sd2048
		|=> remote_q.frac[7:4] == $past(sample.reading[3:0]))
		else $error("remote fraction lost");

	// extended fraction keeps floor semantics, negatives included
	chk_frac_ext: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && sample.remote && wide_q && sample.reading >= -16'sd1024
		&& sample.reading <= 16'sd3071
		|=> remote_q.frac[7:4] == $past(sample.reading[3:0]))
		else $error("extended fraction lost");

	// local extended fraction
	chk_frac_ext_loc: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid && !sample.remote && wide_q && sample.reading >= -16'sd1024
		&& sample.reading <= 16'sd3071
		|=> local_q.frac[7:4] == $past(sample.reading[3:0]))
		else $error("local extended fraction lost");

	// a channel result stands until its own next sample
	chk_local_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		!(sample_valid && !sample.remote)
		|=> $stable(local_q))
		else $error("local result changed without sample");

	// remote result stands likewise
	chk_remote_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		!(sample_valid && sample.remote)
		|=> $stable(remote_q))
		else $error("remote result changed without sample");

	// store strobe follows every sample
	chk_write_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
		sample_valid |=> result_wr)
		else $error("write strobe missing");

	// no strobe without a sample, so the host never fetches twice
	chk_write_idle: assert property (@(posedge core_clk) disable iff (!nrst)
		!sample_valid
		|=> !result_wr)
		else $error("spurious write strobe");
endmodule
`default_nettype wire

// [verification/trf_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module trf_host_model
	import trf_pkg::*;
(
	// watched storage side
	input wire logic core_clk,
	input wire logic result_wr,
	// results fetched so far
	output var int n_read
);
	// host fetches once per store strobe, never more
	initial n_read = 0;
	always @(posedge core_clk) if (result_wr === 1'b1) n_read++;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) checks_done++; if ((s) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end
module tb_top;
	import trf_pkg::*;
	logic core_clk = 0, nrst = 0, conv_start = 0, sample_valid = 0, result_wr, wide_active, wide_m = 0;
	logic [7:0] config_reg = 8'h00;
	trf_sample_type sample = '0;
	trf_result_type local_result, remote_result;
	logic [16:0] q[$], e;
	logic [15:0] lfsr = 16'h002b;
	int n_errors = 0, checks_done = 0, n_read, sent = 0;
	// edges of both ranges, plus fractions
	logic [15:0] tbl[9] = '{16'hfc00, 16'hfbf0, 16'hffff, 16'h0000, 16'h0199,
		16'h07ff, 16'h0800, 16'h0bff, 16'h0c00};
	always #2 core_clk = ~core_clk;
	trf_formatter trf_formatter_inst(.core_clk(core_clk), .nrst(nrst), .config_reg(config_reg),
		.conv_start(conv_start), .sample_valid(sample_valid), .sample(sample),
		.local_result(local_result), .remote_result(remote_result), .result_wr(result_wr),
		.wide_active(wide_active));
	trf_host_model trf_host_model_inst(.core_clk(core_clk), .result_wr(result_wr), .n_read(n_read));
	function automatic logic [15:0] expv(logic signed [15:0] r, logic w);
		int t;
		t = r >>> 4;
		if (w) t += int'(EXT_OFFSET);
		if (t < 0) return 16'h0000;
		if (t > int'(w ? EXT_MAX_CODE : STD_MAX_CODE)) return {w ? EXT_MAX_CODE : STD_MAX_CODE, 8'h00};
		return {t[7:0], r[3:0], 4'h0};
	endfunction
	function automatic logic [15:0] lfsr_next(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// each send sets the config bit opposite the applied range, so only conv_start may switch it
	task automatic send(logic rm, logic [15:0] rd, logic cs);
		@(posedge core_clk);
		`CHK("range", wide_m, wide_active)
		config_reg <= {5'h00, ~wide_m, 2'h0};
		conv_start <= cs;
		sample_valid <= 1'b1;
		sample <= {rm, rd};
		q.push_back({rm, expv(rd, wide_m)});
		if (cs) wide_m = ~wide_m;
		sent++;
		@(posedge core_clk);
		conv_start <= 1'b0;
		sample_valid <= 1'b0;
	endtask
	task automatic complete_run();
		`CHK("reads", sent, n_read)
		`CHK("pending", 0, q.size())
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// oldest note against whatever was just stored
	always @(posedge core_clk) if (result_wr === 1'b1) begin
		e = q.pop_front();
		`CHK("result", e[15:0], e[16] ? remote_result : local_result)
	end
	initial begin
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			send(p[0], tbl[4], 1'b1);
			foreach (tbl[i]) send(i[0], tbl[i], 1'b0);
			repeat (8) begin
				lfsr = lfsr_next(lfsr);
				send(lfsr[15], {{4{lfsr[11]}}, lfsr[11:0]}, 1'b0);
			end
			$display("test pass %0d done", p);
		end
		repeat (4) @(posedge core_clk);
		complete_run();
	end
	// whole run needs under 200 cycles
	initial begin
		#4000;
		n_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
